//--- rtl/status_flag_unit.sv
// Program status flags and their effect on instruction execution.
`timescale 1ns/10ps
// Summary of operation
// - With index enable set, the data address is operand OR index.
// - A zero arithmetic result sets zero flag unless compare hold is 1 or it is stored to the flag word.
// - A nonzero arithmetic result clears the zero flag unless it is stored to the flag word.
// - With compare hold set, arithmetic results are not stored.
// - Only arithmetic or a store to the flag word changes the zero flag; other classes keep it.
// - A bit test clears compare hold; else only explicit writes move it.
// - Add and subtract set carry on carry or borrow, else clear it.
// - Rotate right through carry: old carry to bit 3, bit 0 to carry.
// - Carry changes only on arithmetic, rotate or a store to the flag word, even under compare.
// - Decimal mode selects decimal digit arithmetic, else 4-bit binary.
// - Decimal mode has no effect on logic, bit test or rotate.
// - Arithmetic aimed at the flag word stores there, over flag updates.
// - Writes to fixed-zero bit positions have no effect and they stay 0.
// - Reads of fixed-zero bit positions return 0.
// - Decimal is 7EH bit 0; compare, carry, zero, index: 7FH bits 3..0.
// - All five flags clear on reset and after the interrupt save.
module status_flag_unit
  import flag_pkg::*;
#(
  parameter int ADDR_W = 7
)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic addrValid,
  input wire logic [ADDR_W-1:0] operandAddr,
  input wire logic [ADDR_W-1:0] indexRegister,
  input wire logic execValid,
  input wire op_e opCode,
  input wire logic [3:0] memData,
  input wire logic [3:0] srcData,
  input wire logic destIsGr,
  input wire logic [ADDR_W-1:0] grAddr,
  input wire logic [3:0] fixedZeroMask,
  input wire logic readValid,
  input wire logic [ADDR_W-1:0] readAddr,
  input wire logic [3:0] readMemData,
  input wire logic irqSave,
  output logic [ADDR_W-1:0] effAddr,
  output logic wrEn,
  output logic [ADDR_W-1:0] wrAddr,
  output logic [3:0] wrData,
  output logic [3:0] readData,
  output flags_s flags,
  output flags_s savedFlags
);

  logic isArith;
  logic isSub;
  logic useCarry;
  logic [3:0] addSum;
  logic addCarry;
  logic [ADDR_W-1:0] destAddr;
  logic [3:0] result;
  logic [3:0] storeData;
  logic store;
  logic hitFlagWord;
  logic hitDecWord;
  logic [3:0] operandNibble;

  ////////////////////////////////////////////////////////////////////////
  // Operation decode.

  // Arithmetic class and its carry use.
  always_comb begin
    isArith = (opCode == OP_ADD) || (opCode == OP_ADDC) ||
              (opCode == OP_SUB) || (opCode == OP_SUBC);
    isSub = (opCode == OP_SUB) || (opCode == OP_SUBC);
    useCarry = (opCode == OP_ADDC) || (opCode == OP_SUBC);
  end

  // The flag bits live in this unit, not in data memory, so their own values
  // stand in for the operand bits they occupy: the whole nibble at 7FH, bit 0 at 7EH.
  always_comb begin
    if (effAddr == FLAG_WORD_ADDR) begin
      operandNibble = {flags.cmp, flags.cy, flags.z, flags.index_modify_enable_flag};
    end else if (effAddr == DEC_MODE_ADDR) begin
      operandNibble = {memData[3:1], flags.bcd};
    end else begin
      operandNibble = memData;
    end
  end

  // Decimal mode only reaches the adder, so logic and rotate ignore it.
  nibble_adder u_adder (
    .a(operandNibble),
    .b(srcData),
    .carryIn(useCarry & flags.cy),
    .subtract(isSub),
    .decimal(flags.bcd),
    .sum(addSum),
    .carryOut(addCarry)
  );

  // Result of the current operation before any store decision.
  always_comb begin
    case (opCode)
      OP_ADD, OP_ADDC, OP_SUB, OP_SUBC: result = addSum;
      OP_AND: result = operandNibble & srcData;
      OP_OR: result = operandNibble | srcData;
      OP_XOR: result = operandNibble ^ srcData;
      OP_MOV: result = srcData;
      OP_ROTATE_RIGHT_THROUGH_CARRY: result = {flags.cy, operandNibble[3:1]};
      default: result = operandNibble;
    endcase
  end

  // Destination and store decision; fixed-zero positions are masked off so
  // a write can never set them, whatever the result.
  always_comb begin
    destAddr = destIsGr ? grAddr : effAddr;
    hitFlagWord = (destAddr == FLAG_WORD_ADDR);
    hitDecWord = (destAddr == DEC_MODE_ADDR);
    store = execValid && (opCode != OP_NONE) && (opCode != OP_TEST) &&
            !(isArith && flags.cmp);
    storeData = result & ~fixedZeroMask;
  end

  ////////////////////////////////////////////////////////////////////////
  // Address phase.

  // Index modification of the data address. The enable is taken as it stands
  // in the address phase, so an instruction that sets it only affects the
  // addresses of the instructions after it.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      effAddr <= '0;
    end else if (addrValid) begin
      if (flags.index_modify_enable_flag) begin
        effAddr <= operandAddr | indexRegister;
      end else begin
        effAddr <= operandAddr;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flag state.

  // Flags register. The statements run in priority order: computed carry and
  // zero first, then the bit-test clear, then an explicit store into a flag
  // nibble, which must win so that arithmetic aimed at the flag word loses
  // its own carry. Registered flags are seen by the very next execute.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      flags <= FLAGS_RESET;
    end else if (irqSave) begin
      flags <= FLAGS_RESET;
    end else if (execValid) begin
      if (isArith) begin
        flags.cy <= addCarry;
        if (addSum != 4'h0) begin
          flags.z <= 1'b0;
        end else if (!flags.cmp) begin
          flags.z <= 1'b1;
        end
      end else if (opCode == OP_ROTATE_RIGHT_THROUGH_CARRY) begin
        flags.cy <= operandNibble[0];
      end
      if (opCode == OP_TEST) begin
        flags.cmp <= 1'b0;
      end
      if (store && hitFlagWord) begin
        flags.cmp <= storeData[CMP_BIT];
        flags.cy <= storeData[CY_BIT];
        flags.z <= storeData[Z_BIT];
        flags.index_modify_enable_flag <= storeData[IXE_BIT];
      end
      if (store && hitDecWord) begin
        flags.bcd <= storeData[BCD_BIT];
      end
    end
  end

  // Copy of the flags taken in the cycle the interrupt stack saves them.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      savedFlags <= FLAGS_RESET;
    end else if (irqSave) begin
      savedFlags <= flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data memory write port.

  // Registered write; the flag nibble itself lives here, not in memory.
  // Suppressed stores leave the strobe low, so memory never sees a result.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wrEn <= 1'b0;
      wrAddr <= '0;
      wrData <= 4'h0;
    end else begin
      wrEn <= store && !hitFlagWord;
      wrAddr <= destAddr;
      wrData <= storeData;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port for the system nibbles.

  // Fixed-zero bits always read as zero, whatever sits behind them.
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      readData <= 4'h0;
    end else if (readValid) begin
      if (readAddr == FLAG_WORD_ADDR) begin
        readData <= {flags.cmp, flags.cy, flags.z, flags.index_modify_enable_flag} &
                    ~fixedZeroMask;
      end else if (readAddr == DEC_MODE_ADDR) begin
        readData <= {readMemData[3:1], flags.bcd} & ~fixedZeroMask;
      end else begin
        readData <= readMemData & ~fixedZeroMask;
      end
    end
  end

endmodule : status_flag_unit

//--- rtl/flag_pkg.sv
// Shared constants, operation codes and flag carrier for the flag unit.
package flag_pkg;

  // System addresses of the two nibbles holding the flags.
  localparam logic [6:0] DEC_MODE_ADDR = 7'h7E;
  localparam logic [6:0] FLAG_WORD_ADDR = 7'h7F;

  // Bit positions inside the nibble at the flag word address.
  localparam int CMP_BIT = 3;
  localparam int CY_BIT = 2;
  localparam int Z_BIT = 1;
  localparam int IXE_BIT = 0;
  // Bit position of the decimal mode flag at its own address.
  localparam int BCD_BIT = 0;

  // Decimal adjust figures for one digit.
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
  localparam logic [4:0] BCD_ADJUST = 5'h06;

  // Operation classes issued by the instruction decoder.
  typedef enum logic [3:0] {
    OP_NONE = 4'b0000,
    OP_ADD  = 4'b0001,
    OP_ADDC = 4'b0010,
    OP_SUB  = 4'b0011,
    OP_SUBC = 4'b0100,
    OP_AND  = 4'b0101,
    OP_OR   = 4'b0110,
    OP_XOR  = 4'b0111,
    OP_MOV  = 4'b1000,
    OP_TEST = 4'b1001,
    OP_ROTATE_RIGHT_THROUGH_CARRY = 4'b1010
  } op_e;

  // The five status flags.
  typedef struct packed {
    logic bcd;
    logic cmp;
    logic cy;
    logic z;
    logic index_modify_enable_flag;
  } flags_s;

  localparam flags_s FLAGS_RESET = 5'h00;

endpackage : flag_pkg

//--- rtl/nibble_adder.sv
// One-digit adder and subtractor with binary or decimal adjust.
`timescale 1ns/10ps
module nibble_adder
  import flag_pkg::*;
(
  input wire logic [3:0] a,
  input wire logic [3:0] b,
  input wire logic carryIn,
  input wire logic subtract,
  input wire logic decimal,
  output logic [3:0] sum,
  output logic carryOut
);

  logic [4:0] raw;

  // Binary sum or difference; bit 4 is carry, or borrow for subtraction.
  always_comb begin
    if (subtract) begin
      raw = {1'b0, a} - {1'b0, b} - {4'h0, carryIn};
    end else begin
      raw = {1'b0, a} + {1'b0, b} + {4'h0, carryIn};
    end
  end

  // Decimal adjust only when asked; binary passes the raw digit.
  always_comb begin
    sum = raw[3:0];
    carryOut = raw[4];
    if (decimal) begin
      if (subtract) begin
        if (raw[4]) begin
          sum = raw[3:0] - BCD_ADJUST[3:0];
        end
      end else if (raw > {1'b0, BCD_DIGIT_MAX}) begin
        sum = raw[3:0] + BCD_ADJUST[3:0];
        carryOut = 1'b1;
      end
    end
  end

endmodule : nibble_adder

//--- test/status_flag_properties.sv
// Port checks for the status flag unit.
`timescale 1ns/10ps
module status_flag_properties
  import flag_pkg::*;
#(parameter int ADDR_W = 7)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic addrValid,
  input wire logic [ADDR_W-1:0] operandAddr,
  input wire logic [ADDR_W-1:0] indexRegister,
  input wire logic execValid,
  input wire op_e opCode,
  input wire logic destIsGr,
  input wire logic [ADDR_W-1:0] grAddr,
  input wire logic irqSave,
  input wire logic [3:0] fixedZeroMask,
  input wire logic [ADDR_W-1:0] effAddr,
  input wire logic wrEn,
  input wire logic [3:0] wrData,
  input wire flags_s flags,
  input wire flags_s savedFlags
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Interrupt entry pre-empts execution, so it is excluded here.
  logic go;
  logic ar;
  logic [ADDR_W-1:0] dst;
  assign go = execValid && !irqSave;
  assign dst = destIsGr ? grAddr : effAddr;
  assign ar = opCode inside {OP_ADD, OP_ADDC, OP_SUB, OP_SUBC};
  ////////////////////////////////////////////////////////////////////////
  chk_index_or: assert property (addrValid |=> effAddr ==
    ($past(flags.index_modify_enable_flag) ? $past(operandAddr | indexRegister)
     : $past(operandAddr))) else $error("effective address wrong");
  chk_cmp_nostore: assert property (go && ar && flags.cmp
    |=> !wrEn) else $error("store with compare hold");
  chk_test_clears: assert property (go && opCode == OP_TEST
    |=> !flags.cmp ##0 !wrEn) else $error("bit test kept compare hold");
  chk_z_only_arith: assert property (go && !ar
    && dst != FLAG_WORD_ADDR |=> $stable(flags.z)) else $error("z moved");
  chk_cy_only_arith: assert property (go && !ar
    && opCode != OP_ROTATE_RIGHT_THROUGH_CARRY && dst != FLAG_WORD_ADDR |=> $stable(flags.cy))
    else $error("cy moved");
  chk_irq_clear: assert property (irqSave |=> flags == FLAGS_RESET
    && savedFlags == $past(flags)) else $error("interrupt save wrong");
  chk_fixed_zero: assert property (wrEn |->
    (wrData & $past(fixedZeroMask)) == 4'h0) else $error("fixed bit set");
  chk_nonzero_clr: assert property (wrEn && wrData != 4'h0
    && $past(go && ar) |-> !flags.z) else $error("z kept on nonzero");
  cover property (irqSave);
  cover property (go && ar && flags.cmp);
  cover property (wrEn && flags.cy);
endmodule : status_flag_properties
bind status_flag_unit status_flag_properties #(.ADDR_W(ADDR_W)) u_chk (
  .clk_sys, .resetn, .addrValid, .operandAddr, .indexRegister, .execValid,
  .opCode, .destIsGr, .grAddr, .irqSave, .fixedZeroMask, .effAddr, .wrEn,
  .wrData, .flags, .savedFlags);

//--- test/data_mem_model.sv
// Data memory model standing behind the flag unit.
`timescale 1ns/10ps
module data_mem_model
  import flag_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [6:0] effAddr,
  input wire logic [6:0] readAddr,
  input wire logic wrEn,
  input wire logic [6:0] wrAddr,
  input wire logic [3:0] wrData,
  output logic [3:0] memData,
  output logic [3:0] readMemData
);
  logic [3:0] mem [128];
  // Each nibble starts as its address digit, so operands are predictable.
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = i[3:0];
    end
  end
  // Stores land on the edge that samples the strobe.
  always @(posedge clk_sys) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end
  // Plain array read; the unit supplies its own flag nibbles.
  assign memData = mem[effAddr];
  assign readMemData = mem[readAddr];
endmodule : data_mem_model

//--- test/testbench.sv
// Directed test of the status flag unit.
`timescale 1ns/10ps
module testbench
  import flag_pkg::*;
;
  logic clk_sys = 1'b0, resetn = 1'b0, addrValid = 1'b0, execValid = 1'b0;
  logic readValid = 1'b0, irqSave = 1'b0, wrEn;
  logic destIsGr = 1'b0, useGr = 1'b0;
  logic [6:0] grAddr = 7'h05;
  logic [6:0] operandAddr = 7'h00, readAddr = 7'h00, effAddr, wrAddr;
  logic [3:0] srcData = 4'h0, fixedZeroMask = 4'h0, memData, readMemData;
  logic [3:0] wrData, readData;
  op_e opCode = OP_NONE;
  flags_s flags, savedFlags;
  int err_count = 0;
  int check_count = 0;
  // Free-running system clock, 50 ns period.
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  status_flag_unit u_dut (.clk_sys, .resetn, .addrValid, .operandAddr,
    .indexRegister(7'h0C), .execValid, .opCode, .memData, .srcData,
    .destIsGr, .grAddr, .fixedZeroMask, .readValid, .readAddr,
    .readMemData, .irqSave, .effAddr, .wrEn, .wrAddr, .wrData, .readData,
    .flags, .savedFlags);
  data_mem_model u_mem (.clk_sys, .effAddr, .readAddr, .wrEn, .wrAddr,
    .wrData, .memData, .readMemData);
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string n, input logic [6:0] s,
      input logic [6:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : check
  // Address phase, then execute; returns where results are settled.
  task automatic run(input logic [6:0] a, input op_e op, input logic [3:0] s,
      input logic [3:0] m);
    @(posedge clk_sys);
    addrValid <= 1'b1;
    operandAddr <= a;
    @(posedge clk_sys);
    addrValid <= 1'b0;
    execValid <= 1'b1;
    destIsGr <= useGr;
    opCode <= op;
    srcData <= s;
    fixedZeroMask <= m;
    @(posedge clk_sys);
    execValid <= 1'b0;
    destIsGr <= 1'b0;
    @(negedge clk_sys);
  endtask : run
  task automatic fl(input logic [6:0] e);
    check("flags", {2'b00, flags}, e);
  endtask : fl
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  // A hang is cut short well past the 60 or so cycles the tests need.
  initial begin
    repeat (3000) @(posedge clk_sys);
    err_count++;
    results();
  end
  // Main sequence; flag values read {bcd, cmp, cy, z, ixe}.
  initial begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    @(negedge clk_sys);
    fl(7'h00);
    run(7'h13, OP_ADD, 4'hE, 4'h0);
    fl(7'h04);
    check("sum", {3'b000, wrData}, 7'h01);
    run(7'h15, OP_SUB, 4'h5, 4'h0);
    fl(7'h02);
    run(7'h7F, OP_MOV, 4'h8, 4'h0);
    fl(7'h08);
    run(7'h15, OP_SUB, 4'h0, 4'h0);
    fl(7'h08);
    run(7'h16, OP_SUB, 4'h7, 4'h0);
    fl(7'h0C);
    check("store", {6'h00, wrEn}, 7'h00);
    useGr = 1'b1;
    run(7'h16, OP_ADD, 4'hF, 4'h0);
    useGr = 1'b0;
    check("grstore", {6'h00, wrEn}, 7'h00);
    fl(7'h0C);
    run(7'h20, OP_TEST, 4'h1, 4'h0);
    fl(7'h04);
    run(7'h7F, OP_MOV, 4'h1, 4'h0);
    run(7'h21, OP_AND, 4'hF, 4'h0);
    check("addr", effAddr, 7'h2D);
    fl(7'h01);
    run(7'h7F, OP_ADD, 4'hF, 4'h0);
    fl(7'h00);
    run(7'h7E, OP_MOV, 4'h1, 4'h0);
    fl(7'h10);
    run(7'h13, OP_ROTATE_RIGHT_THROUGH_CARRY, 4'h0, 4'h0);
    fl(7'h14);
    run(7'h12, OP_ROTATE_RIGHT_THROUGH_CARRY, 4'h0, 4'h0);
    check("rot", {3'b000, wrData}, 7'h09);
    run(7'h19, OP_ADD, 4'h3, 4'h0);
    check("bcd", {3'b000, wrData}, 7'h02);
    fl(7'h14);
    run(7'h30, OP_MOV, 4'hF, 4'h8);
    check("fixed", {3'b000, wrData}, 7'h07);
    useGr = 1'b1;
    run(7'h30, OP_MOV, 4'h6, 4'h0);
    useGr = 1'b0;
    check("graddr", wrAddr, 7'h05);
    @(posedge clk_sys);
    readValid <= 1'b1;
    readAddr <= 7'h7F;
    fixedZeroMask <= 4'h4;
    @(posedge clk_sys);
    readAddr <= 7'h7E;
    fixedZeroMask <= 4'hE;
    @(negedge clk_sys);
    check("masked", {3'b000, readData}, 7'h00);
    @(posedge clk_sys);
    readValid <= 1'b0;
    irqSave <= 1'b1;
    @(posedge clk_sys);
    irqSave <= 1'b0;
    @(negedge clk_sys);
    check("read", {3'b000, readData}, 7'h01);
    check("saved", {2'b00, savedFlags}, 7'h14);
    fl(7'h00);
    results();
  end
endmodule : testbench
